// *** link_pkg.sv ***
// Shared constants for the frame buffer link: timing, commands and registers.
package link_pkg;
  // System clock and link timing.
  localparam int unsigned PCLK_PERIOD_NS = 25;
  localparam int unsigned IND_DELAY_NS   = 750;
  localparam int unsigned IND_DELAY_CYC  =
    (IND_DELAY_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int unsigned TIMEOUT_US     = 64;
  localparam int unsigned TIMEOUT_CYC    = TIMEOUT_US * 1000 / PCLK_PERIOD_NS;
  localparam logic [11:0] HALF_CYC       = 12'h008;
  localparam logic [11:0] IND_CNT        = 12'(IND_DELAY_CYC);
  localparam logic [11:0] ABORT_CNT      = 12'(IND_DELAY_CYC + TIMEOUT_CYC);

  // Command byte layout on the link.
  localparam int unsigned CMD_ACC_BIT = 7;
  localparam int unsigned CMD_WR_BIT  = 6;
  localparam logic [2:0]  CMD_FB_RD   = 3'h1;

  // Device registers, addressed by the low six command bits.
  localparam logic [5:0] MISC_CTRL_ADDR  = 6'h04;
  localparam logic [5:0] IRQ_MASK_ADDR   = 6'h0e;
  localparam logic [5:0] IRQ_STATUS_ADDR = 6'h0f;
  localparam logic [7:0] MISC_CTRL_RST   = 8'h22;
  localparam logic [7:0] IRQ_MASK_RST    = 8'h00;
  localparam int unsigned IND_EN_BIT     = 4;
  localparam int unsigned IRQ_POL_BIT    = 0;

  // Frame buffer size.
  localparam int unsigned FB_DEPTH = 128;
  localparam logic [7:0]  FB_FULL  = 8'h80;

  // Controller registers on APB.
  localparam logic [11:0] CFG_OFS   = 12'h000;
  localparam logic [11:0] CMD_OFS   = 12'h004;
  localparam logic [11:0] STAT_OFS  = 12'h008;
  localparam logic [11:0] MASK_OFS  = 12'h00c;
  localparam logic [11:0] RDATA_OFS = 12'h010;
  localparam int unsigned ST_DONE    = 0;
  localparam int unsigned ST_TIMEOUT = 1;
  localparam int unsigned ST_DEVIRQ  = 2;
  localparam int unsigned ST_BYTE    = 3;
  localparam int unsigned ST_W       = 4;
endpackage

// *** spi_link_if.sv ***
// Link wires between the frame buffer device and its controller.
`timescale 1ns/1ps
interface spi_link_if;
  logic sclk;
  logic sel_n;
  logic mosi;
  logic miso;
  logic irq;

  // Device side of the link.
  modport dev (input sclk, input sel_n, input mosi, output miso, output irq);
  // Controller side of the link.
  modport ctl (output sclk, output sel_n, output mosi, input miso, input irq);
endinterface

// *** radio_fb_device.sv ***
// Device end: link slave, frame buffer, interrupt and empty indicator pin.
// Contract
// - host watches pin, gates each byte on it
// - pin low means data ready, host continues
// - pin high means wait, host holds byte
// - pin valid from 750ns after command byte
// - signal empty while payload bytes missing
// - no interrupts on pin during indicator
// - chip select rising ends buffer read
// - pending interrupts shown right after release
// - other accesses show only interrupts
// - receive error locks indicator at empty
// - host aborts after 64us high
// - control bit 4 enables, resets to 0
// - indicator ignores interrupt polarity
//
// Added by the designer: register access over the link.
`timescale 1ns/1ps
module radio_fb_device
  import link_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  spi_link_if.dev         link,
  input  wire logic       rx_start,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_error,
  input  wire logic [7:0] events,
  output logic      [7:0] misc_ctrl
);

  typedef enum logic [4:0] {
    P_IDLE   = 5'b00001,
    P_CMD    = 5'b00010,
    P_REG_RD = 5'b00100,
    P_REG_WR = 5'b01000,
    P_FB     = 5'b10000
  } dev_phase_t;

  logic       sclk_s1_ff, sclk_s2_ff, sclk_d_ff;
  logic       sel_s1_ff, sel_s2_ff, sel_d_ff;
  logic       mosi_s1_ff, mosi_s2_ff;
  logic       rise, fall, sel_fall, byte_end;
  logic [7:0] in_byte;
  dev_phase_t phase_ff, nxt_phase;
  logic [2:0] bit_ff;
  logic [7:0] in_sh_ff;
  logic [7:0] out_sh_ff;
  logic [7:0] misc_ff;
  logic [7:0] mask_ff;
  logic [7:0] status_ff;
  logic [7:0] rd_val;
  logic [5:0] addr_ff;
  logic       status_rd;
  logic       ind_on_ff;
  logic       need_load_ff;
  logic       err_lock_ff;
  logic       can_load;
  logic [7:0] rd_ptr_ff;
  logic [7:0] wr_ptr_ff;
  logic [7:0] wr_idx;
  logic [7:0] mem [FB_DEPTH];
  logic       irq_ff, nxt_irq;
  logic       int_level;

  // Link pins come from the other party, so two flip-flops each.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_d_ff  <= 1'b0;
      sel_s1_ff  <= 1'b1;
      sel_s2_ff  <= 1'b1;
      sel_d_ff   <= 1'b1;
      mosi_s1_ff <= 1'b0;
      mosi_s2_ff <= 1'b0;
    end else begin
      sclk_s1_ff <= link.sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_d_ff  <= sclk_s2_ff;
      sel_s1_ff  <= link.sel_n;
      sel_s2_ff  <= sel_s1_ff;
      sel_d_ff   <= sel_s2_ff;
      mosi_s1_ff <= link.mosi;
      mosi_s2_ff <= mosi_s1_ff;
    end
  end

  // Edge detection compares the second stage with its delayed copy.
  assign rise     = sclk_s2_ff & ~sclk_d_ff & ~sel_s2_ff;
  assign fall     = ~sclk_s2_ff & sclk_d_ff & ~sel_s2_ff;
  assign sel_fall = ~sel_s2_ff & sel_d_ff;
  assign byte_end = rise & (bit_ff == 3'h7);
  assign in_byte  = {in_sh_ff[6:0], mosi_s2_ff};

  // Bit counter cleared while chip select is high; input shifter keeps its value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_ff   <= 3'h0;
      in_sh_ff <= 8'h00;
    end else if (sel_s2_ff) begin
      bit_ff   <= 3'h0;
    end else if (rise) begin
      bit_ff   <= bit_ff + 3'h1;
      in_sh_ff <= in_byte;
    end
  end

  // Access phase decode; chip select release ends any access.
  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      P_IDLE: begin
        if (sel_fall) nxt_phase = P_CMD;
      end
      P_CMD: begin
        if (byte_end) begin
          if (in_byte[CMD_ACC_BIT]) begin
            nxt_phase = in_byte[CMD_WR_BIT] ? P_REG_WR : P_REG_RD;
          end else if (in_byte[7:5] == CMD_FB_RD) begin
            nxt_phase = P_FB;
          end else begin
            nxt_phase = P_IDLE;
          end
        end
      end
      P_REG_RD, P_REG_WR: begin
        if (byte_end) nxt_phase = P_IDLE;
      end
      P_FB: nxt_phase = P_FB;
      default: nxt_phase = P_IDLE;
    endcase
    if (sel_s2_ff) nxt_phase = P_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phase_ff <= P_IDLE;
    else          phase_ff <= nxt_phase;
  end

  // Register read value for the address carried in the command.
  always_comb begin
    case (in_byte[5:0])
      MISC_CTRL_ADDR:  rd_val = misc_ff;
      IRQ_MASK_ADDR:   rd_val = mask_ff;
      IRQ_STATUS_ADDR: rd_val = status_ff;
      default:         rd_val = 8'h00;
    endcase
  end

  assign status_rd = (phase_ff == P_CMD) & byte_end & in_byte[CMD_ACC_BIT] &
                     ~in_byte[CMD_WR_BIT] & (in_byte[5:0] == IRQ_STATUS_ADDR);

  // Register writes take the address latched from the command byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_ff <= MISC_CTRL_RST;
      mask_ff <= IRQ_MASK_RST;
    end else if ((phase_ff == P_REG_WR) && byte_end) begin
      if (addr_ff == MISC_CTRL_ADDR)
        misc_ff <= in_byte;
      if (addr_ff == IRQ_MASK_ADDR)
        mask_ff <= in_byte;
    end
  end

  // The register address is kept from the command byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) addr_ff <= 6'h00;
    else if ((phase_ff == P_CMD) && byte_end) addr_ff <= in_byte[5:0];
  end

  assign misc_ctrl = misc_ff;

  // Sticky interrupt status; a new event wins over the read clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_ff <= 8'h00;
    else          status_ff <= (status_rd ? 8'h00 : status_ff) | events;
  end

  assign int_level = |(status_ff & mask_ff);

  // Frame buffer fill from the receiver; a new frame restarts at zero.
  assign wr_idx = rx_start ? 8'h00 : wr_ptr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff <= 8'h00;
    end else if (rx_valid && (wr_idx < FB_FULL)) begin
      wr_ptr_ff <= wr_idx + 8'h01;
    end else if (rx_start) begin
      wr_ptr_ff <= 8'h00;
    end
  end

  always_ff @(posedge pclk) begin
    if (rx_valid && (wr_idx < FB_FULL)) mem[wr_idx[6:0]] <= rx_data;
  end

  // A byte may be loaded only between bytes and once it has arrived.
  assign can_load = need_load_ff & (bit_ff == 3'h0) & ~err_lock_ff &
                    (rd_ptr_ff < wr_ptr_ff);

  // Indicator ownership is fixed when the buffer read command completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_on_ff <= 1'b0;
    end else if (sel_s2_ff) begin
      ind_on_ff <= 1'b0;
    end else if ((phase_ff == P_CMD) && byte_end &&
                 (in_byte[7:5] == CMD_FB_RD)) begin
      ind_on_ff <= misc_ff[IND_EN_BIT];
    end
  end

  // Each buffer byte is requested at a byte boundary and served when ready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      need_load_ff <= 1'b0;
      rd_ptr_ff    <= 8'h00;
    end else if (sel_s2_ff) begin
      need_load_ff <= 1'b0;
    end else if ((phase_ff == P_CMD) && byte_end &&
                 (in_byte[7:5] == CMD_FB_RD)) begin
      need_load_ff <= 1'b1;
      rd_ptr_ff    <= 8'h00;
    end else if ((phase_ff == P_FB) && byte_end) begin
      need_load_ff <= 1'b1;
    end else if (can_load) begin
      need_load_ff <= 1'b0;
      rd_ptr_ff    <= rd_ptr_ff + 8'h01;
    end
  end

  // A receive error during the read locks the indicator at empty.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) err_lock_ff <= 1'b0;
    else if (sel_s2_ff) err_lock_ff <= 1'b0;
    else if (rx_error && (phase_ff == P_FB) && ind_on_ff)
      err_lock_ff <= 1'b1;
  end

  // Output shifter: loads on command or buffer byte, shifts on falling edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sh_ff <= 8'h00;
    end else if ((phase_ff == P_CMD) && byte_end) begin
      out_sh_ff <= rd_val;
    end else if (can_load) begin
      out_sh_ff <= mem[rd_ptr_ff[6:0]];
    end else if (fall && (bit_ff != 3'h0)) begin
      out_sh_ff <= {out_sh_ff[6:0], 1'b0};
    end
  end

  assign link.miso = out_sh_ff[7];

  // Pin source: indicator while it owns the pin, interrupts otherwise.
  always_comb begin
    if (ind_on_ff && (phase_ff == P_FB)) begin
      nxt_irq = need_load_ff | err_lock_ff;
    end else begin
      nxt_irq = int_level ^ misc_ff[IRQ_POL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_ff <= 1'b0;
    else          irq_ff <= nxt_irq;
  end

  assign link.irq = irq_ff;

endmodule // radio_fb_device

// *** fb_read_controller.sv ***
// Controller end: APB registers, link master and indicator gating.
`timescale 1ns/1ps
module fb_read_controller
  import link_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq_o,
  output logic             byte_valid,
  output logic      [7:0]  byte_data,
  spi_link_if.ctl          link
);

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_SEL  = 6'b000010,
    S_LOW  = 6'b000100,
    S_HIGH = 6'b001000,
    S_GATE = 6'b010000,
    S_END  = 6'b100000
  } ctl_state_t;

  ctl_state_t          state_ff;
  logic                miso_s1_ff, miso_s2_ff, irq_s1_ff, irq_s2_ff;
  logic                acc, wr_en, rd_en, mapped, start, half_done;
  logic                cfg_ff, gate_ff, first_ff, sclk_ff, sel_n_ff;
  logic [ST_W-1:0]     status_ff, mask_ff, set_ev;
  logic [7:0]          tx_sh_ff, rx_sh_ff, wdata_ff, count_ff, rdata_ff;
  logic [2:0]          bit_ff;
  logic [11:0]         cnt_ff;

  // Pins from the device pass two flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_s1_ff <= 1'b0;
      miso_s2_ff <= 1'b0;
      irq_s1_ff  <= 1'b0;
      irq_s2_ff  <= 1'b0;
    end else begin
      miso_s1_ff <= link.miso;
      miso_s2_ff <= miso_s1_ff;
      irq_s1_ff  <= link.irq;
      irq_s2_ff  <= irq_s1_ff;
    end
  end

  // APB decode; the slave always answers in the first access cycle.
  assign acc    = psel & penable;
  assign mapped = (paddr == CFG_OFS) | (paddr == CMD_OFS) |
                  (paddr == STAT_OFS) | (paddr == MASK_OFS) |
                  (paddr == RDATA_OFS);
  assign wr_en  = acc & pwrite & mapped;
  assign rd_en  = acc & ~pwrite;
  assign start  = wr_en & (paddr == CMD_OFS) & (state_ff == S_IDLE);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  always_comb begin
    case (paddr)
      CFG_OFS:   prdata = {31'h0, cfg_ff};
      CMD_OFS:   prdata = {8'h00, count_ff, wdata_ff, tx_sh_ff};
      STAT_OFS:  prdata = {28'h0, status_ff};
      MASK_OFS:  prdata = {28'h0, mask_ff};
      RDATA_OFS: prdata = {23'h0, state_ff != S_IDLE, rdata_ff};
      default:   prdata = 32'h0;
    endcase
  end

  // Configuration and mask registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff  <= 1'b0;
      mask_ff <= '0;
    end else if (wr_en && (paddr == CFG_OFS)) begin
      cfg_ff  <= pwdata[0];
    end else if (wr_en && (paddr == MASK_OFS)) begin
      mask_ff <= pwdata[ST_W-1:0];
    end
  end

  // Sticky status; events win over the clear done by reading it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_ff <= '0;
    else if (rd_en && (paddr == STAT_OFS)) status_ff <= set_ev;
    else status_ff <= status_ff | set_ev;
  end

  assign irq_o = |(status_ff & mask_ff);
  assign set_ev[ST_DEVIRQ]  = irq_s2_ff & sel_n_ff;
  assign set_ev[ST_DONE]    = (state_ff == S_END) & half_done;
  assign set_ev[ST_TIMEOUT] = (state_ff == S_GATE) & (cnt_ff >= ABORT_CNT);
  assign set_ev[ST_BYTE]    = byte_valid;
  assign half_done = (cnt_ff == HALF_CYC - 12'h001);

  // Link sequencer: select, eight clocks per byte, gating, release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= S_IDLE;
      cnt_ff     <= 12'h000;
      bit_ff     <= 3'h0;
      sclk_ff    <= 1'b0;
      sel_n_ff   <= 1'b1;
      first_ff   <= 1'b0;
      gate_ff    <= 1'b0;
      tx_sh_ff   <= 8'h00;
      rx_sh_ff   <= 8'h00;
      wdata_ff   <= 8'h00;
      count_ff   <= 8'h00;
      rdata_ff   <= 8'h00;
      byte_valid <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      cnt_ff     <= cnt_ff + 12'h001;
      case (state_ff)
        S_IDLE: begin
          cnt_ff <= 12'h000;
          if (start) begin
            tx_sh_ff <= pwdata[7:0];
            wdata_ff <= pwdata[15:8];
            count_ff <= pwdata[23:16];
            gate_ff  <= cfg_ff & (pwdata[7:5] == CMD_FB_RD);
            first_ff <= 1'b1;
            bit_ff   <= 3'h0;
            sel_n_ff <= 1'b0;
            state_ff <= S_SEL;
          end
        end
        S_SEL, S_LOW: begin
          if (half_done) begin
            sclk_ff  <= 1'b1;
            rx_sh_ff <= {rx_sh_ff[6:0], miso_s2_ff};
            cnt_ff   <= 12'h000;
            state_ff <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (half_done) begin
            sclk_ff <= 1'b0;
            cnt_ff  <= 12'h000;
            bit_ff  <= bit_ff + 3'h1;
            if (bit_ff != 3'h7) begin
              tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
              state_ff <= S_LOW;
            end else begin
              if (!first_ff) begin
                rdata_ff   <= rx_sh_ff;
                byte_valid <= 1'b1;
              end
              first_ff <= 1'b0;
              tx_sh_ff <= first_ff ? wdata_ff : 8'h00;
              if (count_ff == 8'h00) begin
                state_ff <= S_END;
              end else begin
                count_ff <= count_ff - 8'h01;
                state_ff <= gate_ff ? S_GATE : S_LOW;
              end
            end
          end
        end
        S_GATE: begin
          // Pin is ignored until it is valid, then low lets the byte go.
          if (cnt_ff >= ABORT_CNT) begin
            cnt_ff   <= 12'h000;
            state_ff <= S_END;
          end else if ((cnt_ff >= IND_CNT) && !irq_s2_ff) begin
            cnt_ff   <= 12'h000;
            state_ff <= S_LOW;
          end
        end
        S_END: begin
          sel_n_ff <= 1'b1;
          if (half_done) begin
            cnt_ff   <= 12'h000;
            state_ff <= S_IDLE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  assign byte_data  = rdata_ff;
  assign link.sclk  = sclk_ff;
  assign link.sel_n = sel_n_ff;
  assign link.mosi  = tx_sh_ff[7];

endmodule // fb_read_controller

// *** frame_buffer_empty_indicator_props.sv ***
// Assertions on the link wires between the device and the controller.
`timescale 1ns/1ps
module frame_buffer_empty_indicator_props
  import link_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic irq
);
  logic        sclk_ff;
  logic        fb_ff;
  logic [15:0] bits_ff;
  logic [7:0]  mo_ff;
  logic [7:0]  mi_ff;
  logic [7:0]  cmd_ff;
  logic [7:0]  ctl_ff;
  int unsigned gap_ff;
  int unsigned hold_ff;
  wire         rise  = sclk & ~sclk_ff;
  wire  [7:0]  mo_nx = {mo_ff[6:0], mosi};
  wire         start = rise && bits_ff >= 16'd8 && bits_ff[2:0] == 3'h0;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Finds link clock rises and shifts both data lines, MSB first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_ff <= 1'b0;
      bits_ff <= '0;
      mo_ff   <= '0;
      mi_ff   <= '0;
    end else begin
      sclk_ff <= sclk;
      bits_ff <= sel_n ? '0 : bits_ff + 16'(rise);
      if (rise) begin
        mo_ff <= mo_nx;
        mi_ff <= {mi_ff[6:0], miso};
      end
    end
  end

  // Keeps the command byte and a mirror of the misc control register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= '0;
      ctl_ff <= MISC_CTRL_RST;
      fb_ff  <= 1'b0;
    end else if (sel_n) begin
      fb_ff <= 1'b0;
    end else if (rise && bits_ff == 16'd7) begin
      cmd_ff <= mo_nx;
      fb_ff  <= mo_nx[7:5] == CMD_FB_RD && ctl_ff[IND_EN_BIT];
    end else if (rise && bits_ff == 16'd15 && cmd_ff[7:6] == 2'b11
                 && cmd_ff[5:0] == MISC_CTRL_ADDR) begin
      ctl_ff <= mo_nx;
    end
  end

  // Counts cycles since the last clock rise and indicator high time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_ff  <= '0;
      hold_ff <= '0;
    end else begin
      gap_ff  <= rise ? '0 : gap_ff + 1;
      hold_ff <= (fb_ff && irq) ? hold_ff + 1 : '0;
    end
  end

  sequence s_quiet; !sclk [*8]; endsequence
  sequence s_high; sclk [*8] ##1 !sclk; endsequence
  property p_idle; sel_n |-> !sclk; endproperty
  property p_lead; $fell(sel_n) |-> s_quiet; endproperty
  property p_half; $rose(sclk) |-> s_high; endproperty
  property p_tail; $rose(sel_n) |-> sel_n [*8]; endproperty
  property p_settle; fb_ff && start |-> gap_ff >= IND_CNT; endproperty
  property p_gate; fb_ff && start |-> !$past(irq); endproperty
  property p_reg;
    rise && bits_ff == 16'd15 && cmd_ff == {2'b10, MISC_CTRL_ADDR}
      |-> {mi_ff[6:0], miso} == ctl_ff;
  endproperty
  property p_abort; hold_ff <= ABORT_CNT + 16; endproperty

  a_idle: assert property (p_idle) else $error("clock while idle");
  a_lead: assert property (p_lead) else $error("early clock");
  a_half: assert property (p_half) else $error("bad high half");
  a_tail: assert property (p_tail) else $error("short release");
  a_settle: assert property (p_settle) else $error("early byte");
  a_gate: assert property (p_gate) else $error("byte while high");
  a_reg: assert property (p_reg) else $error("control readback");
  a_abort: assert property (p_abort) else $error("no abort");
endmodule // frame_buffer_empty_indicator_props

// *** frame_buffer_empty_indicator_tb_top.sv ***
// Self-checking bench for the frame buffer read link with both ends.
`timescale 1ns/1ps
module frame_buffer_empty_indicator_tb_top
  import link_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq_o, byte_valid, err, rx_start, rx_valid, rx_error;
  logic        lo_seen, hi_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic [7:0]  byte_data, rx_data, events, misc_ctrl, ev;
  logic [7:0]  got_q[$];
  logic [7:0]  exp_q[$];
  int          bad_count, compares, seed, k;

  spi_link_if spi_link_if_i ();
  radio_fb_device radio_fb_device_i (.pclk(pclk), .presetn(presetn),
    .link(spi_link_if_i), .rx_start(rx_start), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_error(rx_error), .events(events),
    .misc_ctrl(misc_ctrl));
  fb_read_controller fb_read_controller_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_o(irq_o), .byte_valid(byte_valid), .byte_data(byte_data),
    .link(spi_link_if_i));
  frame_buffer_empty_indicator_props props_i (.pclk(pclk),
    .presetn(presetn), .sclk(spi_link_if_i.sclk),
    .sel_n(spi_link_if_i.sel_n), .mosi(spi_link_if_i.mosi),
    .miso(spi_link_if_i.miso), .irq(spi_link_if_i.irq));

  // Makes the 40 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Notes the pin levels seen while the device is selected.
  always @(posedge pclk) begin
    if (spi_link_if_i.sel_n === 1'b0) begin
      if (spi_link_if_i.irq === 1'b0) lo_seen <= 1'b1;
      if (spi_link_if_i.irq === 1'b1) hi_seen <= 1'b1;
    end
    if (byte_valid === 1'b1) got_q.push_back(byte_data);
  end

  // Compares one result and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the answer is taken at the edge where pready is high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Starts a link command, waits for idle, keeps status and last byte.
  task automatic run(input logic [7:0] c, input logic [7:0] d,
                     input logic [7:0] n);
    apb(1'b1, CMD_OFS, {8'h00, n, d, c});
    do begin
      apb(1'b0, RDATA_OFS, 32'h0);
    end while (rd[8] !== 1'b0);
    repeat (12) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0);
    st = rd;
    apb(1'b0, RDATA_OFS, 32'h0);
  endtask

  // Expected control register value for a given enable and polarity.
  function automatic logic [7:0] exp_misc(input logic en, input logic pol);
    exp_misc              = MISC_CTRL_RST;
    exp_misc[IND_EN_BIT]  = en;
    exp_misc[IRQ_POL_BIT] = pol;
  endfunction

  // Sets the indicator enable, polarity and controller gating together.
  task automatic mode(input logic en, input logic pol);
    run({2'b11, MISC_CTRL_ADDR}, exp_misc(en, pol), 1);
    apb(1'b1, CFG_OFS, {31'h0, en});
    chk(misc_ctrl, exp_misc(en, pol));
    got_q.delete();
    exp_q.delete();
    lo_seen <= 1'b0;
    hi_seen <= 1'b0;
  endtask

  // Pulses frame start and stores payload bytes into the device.
  task automatic feed(input logic s, input logic [7:0] d);
    @(posedge pclk);
    rx_start <= s;
    rx_valid <= ~s;
    rx_data  <= d;
    @(posedge pclk);
    rx_start <= 1'b0;
    rx_valid <= 1'b0;
    if (!s) exp_q.push_back(d);
  endtask

  // Waits a few cycles and settles before sampling.
  task automatic look;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic wrap_up;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up();
  end

  // Main sequence of scenarios.
  initial begin
    seed = 32'hb4f13ad9;
    {presetn, psel, penable, pwrite, rx_start, rx_valid, rx_error} = '0;
    {paddr, pwdata, rx_data, events, lo_seen, hi_seen} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    look();
    chk(misc_ctrl, MISC_CTRL_RST);
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    run({2'b10, MISC_CTRL_ADDR}, 8'h00, 1);
    chk(rd[7:0], MISC_CTRL_RST);
    ev = $random(seed);
    run({2'b11, MISC_CTRL_ADDR}, ev, 1);
    run({2'b10, MISC_CTRL_ADDR}, 8'h00, 1);
    chk({misc_ctrl, rd[7:0]}, {ev, ev});
    // A pending device interrupt shows on the pin and reaches irq_o.
    mode(1'b0, 1'b0);
    run({2'b11, IRQ_MASK_ADDR}, 8'hff, 1);
    ev = $random(seed) | 8'h01;
    @(posedge pclk);
    events <= ev;
    @(posedge pclk);
    events <= 8'h00;
    look();
    chk({spi_link_if_i.irq, irq_o}, 2'b10);
    apb(1'b1, MASK_OFS, 32'h1 << ST_DEVIRQ);
    look();
    chk(irq_o, 1'b1);
    // Indicator off: a buffer read keeps the pin for the interrupt.
    feed(1'b1, 8'h00);
    feed(1'b0, $random(seed));
    feed(1'b0, $random(seed));
    mode(1'b0, 1'b0);
    run(8'h20, 8'h00, 2);
    chk(lo_seen, 1'b0);
    // Indicator on with data ready: interrupt hidden, then shown again.
    mode(1'b1, 1'b0);
    feed(1'b1, 8'h00);
    feed(1'b0, $random(seed));
    feed(1'b0, $random(seed));
    run(8'h20, 8'h00, 2);
    chk(lo_seen, 1'b1);
    chk(got_q.size(), 2);
    foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
    look();
    chk(spi_link_if_i.irq, 1'b1);
    run({2'b10, IRQ_STATUS_ADDR}, 8'h00, 1);
    chk(rd[7:0], ev);
    apb(1'b0, STAT_OFS, 32'h0);
    look();
    chk({spi_link_if_i.irq, irq_o}, 2'b00);
    // Slow arrival of payload under both interrupt polarities.
    for (int pol = 0; pol < 2; pol++) begin
      mode(1'b1, pol[0]);
      feed(1'b1, 8'h00);
      fork
        run(8'h20, 8'h00, 3);
        repeat (3) begin
          repeat (150) @(posedge pclk);
          feed(1'b0, $random(seed));
        end
      join
      chk(got_q.size(), 3);
      foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
      chk({hi_seen, lo_seen, st[ST_DONE]}, 3'b111);
    end
    // A receive error locks the indicator and the read times out.
    mode(1'b1, 1'b0);
    feed(1'b1, 8'h00);
    feed(1'b0, $random(seed));
    fork
      run(8'h20, 8'h00, 3);
      begin
        k = 0;
        while (got_q.size() < 1 && k < 3000) begin
          @(posedge pclk);
          k++;
        end
        rx_error <= 1'b1;
        @(posedge pclk);
        rx_error <= 1'b0;
        repeat (100) @(posedge pclk);
        feed(1'b0, $random(seed));
      end
    join
    chk(got_q.size(), 1);
    chk(st[ST_TIMEOUT], 1'b1);
    wrap_up();
  end
endmodule // frame_buffer_empty_indicator_tb_top
